// >>> rtl/slp_clock_gate.v
/*
 Sleep mode controller: picks which clock domains run while asleep.
 Assumes sleep_req and wake_irq are synchronous to clk; hw_reset_n is a pin.
 Assumes each gated domain takes its clk_en bit and gates its own clock glitch-free.
 Assumes wake_irq is the core's combined interrupt line, already masked by enables.
*/
// Operation
// - Six sleep modes are offered, chosen by software before sleeping.
// - Idle stops the processor clock; memory, timers, serial, interrupts keep running.
// - Deepest mode stops the oscillator and all functions; registers are kept.
// - After deepest mode, an interrupt or hardware reset resumes operation.
// - Power-save keeps the asynchronous timer running; all else sleeps.
// - Noise reduction keeps only the oscillator, asynchronous timer and converter running.
// - Standby keeps the main oscillator running while everything else sleeps.
// - Extended standby keeps main oscillator and asynchronous timer running.
`timescale 1ns/1ps
`include "slp_consts.vh"

module slp_clock_gate (
	input  wire                    clk,          // System clock, 200 MHz
	input  wire                    rst,          // Synchronous reset, active high
	input  wire [`SLP_MODE_W-1:0]  sleep_mode,   // Selected sleep mode
	input  wire                    sleep_req,    // One-cycle sleep request from core
	input  wire                    wake_irq,     // Interrupt wake-up source
	input  wire                    hw_reset_n,   // Hardware reset pin, active low
	output reg  [`SLP_EN_W-1:0]    clk_en,       // Per-domain clock enables
	output reg                     asleep,       // High while in a sleep mode
	output reg                     mode_err      // Last request named an unknown mode
);

	reg                    hw_rst_meta;
	reg                    hw_rst_sync;
	reg                    state;
	reg                    next_state;
	reg [`SLP_EN_W-1:0]    next_clk_en;
	reg                    next_mode_err;
	wire                   wake;
	wire [`SLP_EN_W:0]     req_enables;
	wire                   mode_known;
	wire                   req_taken;

	// Enables kept running per mode
	function [`SLP_EN_W:0] mode_enables;
		input [`SLP_MODE_W-1:0] mode;
		begin
			mode_enables = {1'b0, `SLP_EN_W'h00};
			case (mode)
			`SLP_MODE_IDLE: begin
				mode_enables[`SLP_EN_CPU]    = 1'b0;
				mode_enables[`SLP_EN_MEM]    = 1'b1;
				mode_enables[`SLP_EN_TIMER]  = 1'b1;
				mode_enables[`SLP_EN_SERIAL] = 1'b1;
				mode_enables[`SLP_EN_IRQ]    = 1'b1;
				mode_enables[`SLP_EN_ADC]    = 1'b1;
				mode_enables[`SLP_EN_OSC]    = 1'b1;
				mode_enables[`SLP_EN_ASYNC]  = 1'b1;
			end

			`SLP_MODE_NOISE: begin
				mode_enables[`SLP_EN_CPU]    = 1'b0;
				mode_enables[`SLP_EN_MEM]    = 1'b0;
				mode_enables[`SLP_EN_TIMER]  = 1'b0;
				mode_enables[`SLP_EN_SERIAL] = 1'b0;
				mode_enables[`SLP_EN_IRQ]    = 1'b0;
				mode_enables[`SLP_EN_ADC]    = 1'b1;
				mode_enables[`SLP_EN_OSC]    = 1'b1;
				mode_enables[`SLP_EN_ASYNC]  = 1'b1;
			end

			`SLP_MODE_PDOWN: begin
				mode_enables[`SLP_EN_CPU]    = 1'b0;
				mode_enables[`SLP_EN_MEM]    = 1'b0;
				mode_enables[`SLP_EN_TIMER]  = 1'b0;
				mode_enables[`SLP_EN_SERIAL] = 1'b0;
				mode_enables[`SLP_EN_IRQ]    = 1'b0;
				mode_enables[`SLP_EN_ADC]    = 1'b0;
				mode_enables[`SLP_EN_OSC]    = 1'b0;
				mode_enables[`SLP_EN_ASYNC]  = 1'b0;
			end

			`SLP_MODE_PSAVE: begin
				mode_enables[`SLP_EN_CPU]    = 1'b0;
				mode_enables[`SLP_EN_MEM]    = 1'b0;
				mode_enables[`SLP_EN_TIMER]  = 1'b0;
				mode_enables[`SLP_EN_SERIAL] = 1'b0;
				mode_enables[`SLP_EN_IRQ]    = 1'b0;
				mode_enables[`SLP_EN_ADC]    = 1'b0;
				mode_enables[`SLP_EN_OSC]    = 1'b0;
				mode_enables[`SLP_EN_ASYNC]  = 1'b1;
			end

			`SLP_MODE_STANDBY: begin
				mode_enables[`SLP_EN_CPU]    = 1'b0;
				mode_enables[`SLP_EN_MEM]    = 1'b0;
				mode_enables[`SLP_EN_TIMER]  = 1'b0;
				mode_enables[`SLP_EN_SERIAL] = 1'b0;
				mode_enables[`SLP_EN_IRQ]    = 1'b0;
				mode_enables[`SLP_EN_ADC]    = 1'b0;
				mode_enables[`SLP_EN_OSC]    = 1'b1;
				mode_enables[`SLP_EN_ASYNC]  = 1'b0;
			end

			`SLP_MODE_EXTSTBY: begin
				mode_enables[`SLP_EN_CPU]    = 1'b0;
				mode_enables[`SLP_EN_MEM]    = 1'b0;
				mode_enables[`SLP_EN_TIMER]  = 1'b0;
				mode_enables[`SLP_EN_SERIAL] = 1'b0;
				mode_enables[`SLP_EN_IRQ]    = 1'b0;
				mode_enables[`SLP_EN_ADC]    = 1'b0;
				mode_enables[`SLP_EN_OSC]    = 1'b1;
				mode_enables[`SLP_EN_ASYNC]  = 1'b1;
			end

			default: begin
				mode_enables = {1'b1, `SLP_EN_ALL}; // Unknown code: stay awake
			end
			endcase
		end
	endfunction

	// Pin synchroniser
	// Pin is asynchronous to clk, so only the second flop is read
	always @(posedge clk) begin
		if (rst) begin
			hw_rst_meta <= 1'b0;
			hw_rst_sync <= 1'b0;
		end else begin
			hw_rst_meta <= ~hw_reset_n;
			hw_rst_sync <= hw_rst_meta;
		end
	end

	assign wake = wake_irq | hw_rst_sync;

	localparam ST_RUN   = `SLP_ST_RUN;
	localparam ST_SLEEP = `SLP_ST_SLEEP;

	assign req_enables = mode_enables(sleep_mode);
	assign mode_known  = ~req_enables[`SLP_EN_W];
	assign req_taken   = sleep_req & (state == ST_RUN);

	// Sleep on an accepted known mode, run again on any wake
	always @* begin
		next_state = state;
		case (state)
		ST_RUN: begin
			if (req_taken && mode_known) begin
				next_state = ST_SLEEP;
			end
		end
		ST_SLEEP: begin
			if (wake) begin
				next_state = ST_RUN;
			end
		end
		default: begin
			next_state = ST_RUN;
		end
		endcase
	end

	// Enables and error flag follow the accepted request or the wake
	always @* begin
		next_clk_en   = clk_en;
		next_mode_err = mode_err;
		case (state)
		ST_RUN: begin
			if (req_taken) begin
				next_mode_err = ~mode_known;
				if (mode_known) begin
					next_clk_en = req_enables[`SLP_EN_W-1:0];
				end else begin
					next_clk_en = `SLP_EN_ALL;
				end
			end
		end
		ST_SLEEP: begin
			if (wake) begin
				next_clk_en = `SLP_EN_ALL;
			end
		end
		default: begin
			next_clk_en = `SLP_EN_ALL;
		end
		endcase
	end

	// Registers elsewhere are never reset by sleep, only clocks stop
	always @(posedge clk) begin
		if (rst) begin
			state <= ST_RUN;
		end else begin
			state <= next_state;
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			clk_en <= `SLP_EN_ALL;
		end else begin
			clk_en <= next_clk_en;
		end
	end

	// Separate flop so the output never comes from logic
	always @(posedge clk) begin
		if (rst) begin
			asleep <= 1'b0;
		end else begin
			asleep <= next_state;
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			mode_err <= 1'b0;
		end else begin
			mode_err <= next_mode_err;
		end
	end

endmodule

// >>> rtl/slp_consts.vh
/*
 Constants for the sleep mode clock gating block: mode codes, enable bit positions.
 Assumes inclusion by rtl/slp_clock_gate.v only.
*/
`ifndef SLP_CONSTS_VH
`define SLP_CONSTS_VH

`define SLP_MODE_W        3
`define SLP_MODE_IDLE     3'h0
`define SLP_MODE_NOISE    3'h1
`define SLP_MODE_PDOWN    3'h2
`define SLP_MODE_PSAVE    3'h3
`define SLP_MODE_STANDBY  3'h6
`define SLP_MODE_EXTSTBY  3'h7

`define SLP_EN_W          8
`define SLP_EN_CPU        0
`define SLP_EN_MEM        1
`define SLP_EN_TIMER      2
`define SLP_EN_SERIAL     3
`define SLP_EN_IRQ        4
`define SLP_EN_ADC        5
`define SLP_EN_OSC        6
`define SLP_EN_ASYNC      7
`define SLP_EN_ALL        8'hff

`define SLP_ST_RUN        1'h0
`define SLP_ST_SLEEP      1'h1

`endif

// >>> verif/slp_chk_properties.sv
/* Sleep gate checker. Bound to slp_clock_gate. */
`timescale 1ns/1ps
module slp_chk (
	input wire       clk,        // Clock
	input wire       rst,        // Reset, active high
	input wire [2:0] sleep_mode, // Mode
	input wire       sleep_req,  // Request
	input wire       wake_irq,   // Wake
	input wire       hw_reset_n, // Hardware reset pin, active low
	input wire [7:0] clk_en,     // Enables
	input wire       asleep,     // Asleep
	input wire       mode_err    // Bad code
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire [3:0] g = {sleep_req && !asleep, sleep_mode};
	idle_en_a: assert property (g == 4'h8 |=> clk_en == 8'hfe) else $error("idle");
	deep_en_a: assert property (g == 4'ha |=> !clk_en && asleep) else $error("deep");
	save_en_a: assert property (g == 4'hb |=> clk_en == 8'h80) else $error("save");
	noise_en_a: assert property (g == 4'h9 |=> clk_en == 8'he0) else $error("noise");
	stby_en_a: assert property (g == 4'he |=> clk_en == 8'h40) else $error("stby");
	ext_en_a: assert property (g == 4'hf |=> clk_en == 8'hc0) else $error("ext");
	bad_mode_a: assert property (g == 4'hc || g == 4'hd |=> !asleep && mode_err)
		else $error("bad");
	irq_wake_a: assert property (asleep && wake_irq |=> !asleep && &clk_en)
		else $error("wake");
	hold_sleep_a: assert property (asleep && !wake_irq && $past(hw_reset_n, 2)
		|=> asleep) else $error("left sleep without a wake");
	pin_wake_a: assert property (asleep && !$past(hw_reset_n, 2) && !$past(rst, 2)
		|=> !asleep && &clk_en) else $error("pin wake");
endmodule

// >>> verif/slp_clock_gate_test.sv
/* Bench for slp_clock_gate. Assumes rtl and checker. */
`timescale 1ns/1ps
module slp_clock_gate_test;
	reg clk = 1'h0, rst = 1'h1, sleep_req = 1'h0, wake_irq = 1'h0, hw_reset_n = 1'h1;
	reg [2:0] sleep_mode = 3'h0;
	wire [7:0] clk_en;
	wire asleep, mode_err;
	wire [9:0] st = {clk_en, asleep, mode_err};
	localparam [63:0] ens = 64'hc040ffff8000e0fe;
	integer bad_count = 0, samples_checked = 0;
	slp_clock_gate uut (
		.clk        (clk),        // Clock
		.rst        (rst),        // Reset
		.sleep_mode (sleep_mode), // Mode
		.sleep_req  (sleep_req),  // Request
		.wake_irq   (wake_irq),   // Interrupt wake
		.hw_reset_n (hw_reset_n), // Pin wake
		.clk_en     (clk_en),     // Enables
		.asleep     (asleep),     // Asleep
		.mode_err   (mode_err)    // Bad code
	);
	always #2.5 clk = ~clk;
	task check(input [9:0] seen, want);
		samples_checked++;
		if (seen !== want) begin
			bad_count++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task sleep(input [2:0] m);
		@(negedge clk) sleep_mode = m;
		sleep_req = 1'h1;
		@(negedge clk) sleep_req = 1'h0;
	endtask
	task test_modes;
		reg b;
		for (int i = 0; i < 8; i++) begin
			b = i[2:1] == 2'h2;
			sleep(i[2:0]);
			check(st, {ens[i*8 +: 8], !b, b});
			@(negedge clk) wake_irq = 1'h1;
			@(negedge clk) wake_irq = 1'h0;
			check(st, {8'hff, 1'h0, b});
		end
		$display("modes done");
	endtask
	task test_pin;
		sleep(3'h2);
		sleep(3'h0);
		check(st, 10'h002);
		@(negedge clk) hw_reset_n = 1'h0;
		repeat (2) @(negedge clk);
		check(st, 10'h002);
		@(negedge clk) check(st, 10'h3fc);
		hw_reset_n = 1'h1;
		repeat (2) @(negedge clk);
		$display("pin done");
	endtask
	task test_reset;
		sleep(3'h3);
		@(negedge clk) rst = 1'h1;
		@(negedge clk) check(st, 10'h3fc);
		rst = 1'h0;
		sleep(3'h7);
		check(st, 10'h302);
		@(negedge clk) wake_irq = 1'h1;
		@(negedge clk) wake_irq = 1'h0;
		check(st, 10'h3fc);
		$display("reset done");
	endtask
	task tally_and_finish;
		$display("%0d checks %0d bad", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge clk);
		rst = 1'h0;
		test_modes;
		test_reset;
		test_pin;
		tally_and_finish;
	end
	initial begin
		#2000;
		bad_count++;
		tally_and_finish;
	end
endmodule
bind slp_clock_gate slp_chk chk (
	.clk        (clk),
	.rst        (rst),
	.sleep_mode (sleep_mode),
	.sleep_req  (sleep_req),
	.wake_irq   (wake_irq),
	.hw_reset_n (hw_reset_n),
	.clk_en     (clk_en),
	.asleep     (asleep),
	.mode_err   (mode_err)
);
